// ==== src/detect_pkg.sv ====
package detect_pkg;

  // Register indices (page * 128 + register); byte address is four times the index
  localparam logic [9:0]  DETECT_EN_IDX   = 10'h078;  // Page 0, register 120
  localparam logic [9:0]  ALERT_CFG_IDX   = 10'h09e;  // Page 1, register 30
  localparam logic [11:0] DETECT_EN_ADDR  = {DETECT_EN_IDX, 2'b00};
  localparam logic [11:0] ALERT_CFG_ADDR  = {ALERT_CFG_IDX, 2'b00};
  localparam logic [11:0] SOURCE_CFG_ADDR = 12'h300;  // Source and threshold
  localparam logic [11:0] STATUS_ADDR     = 12'h304;  // Sticky events, write one to clear
  localparam logic [11:0] MASK_ADDR       = 12'h308;  // Interrupt mask, same layout
  localparam logic [11:0] RECORD_ADDR     = 12'h30c;  // Recording state, write one to stop

  // Field positions
  localparam int VOICE_EN_BIT     = 2;
  localparam int ULTRA_EN_BIT     = 3;
  localparam int ALERT_LSB        = 6;
  localparam int CHAN_LSB         = 4;
  localparam int SRC_DIGITAL_BIT  = 16;
  localparam int VOICE_EVT_BIT    = 0;
  localparam int ULTRA_EVT_BIT    = 1;
  localparam int RECORD_BIT       = 0;

  // Reset values
  localparam logic [15:0] THRESHOLD_RESET = 16'h0800;
  localparam logic [1:0]  MASK_RESET      = 2'h3;

  // Alert modes
  localparam logic [1:0] ALERT_IRQ  = 2'h0;  // Interrupt only
  localparam logic [1:0] ALERT_WAKE = 2'h1;  // Auto wake and record
  localparam logic [1:0] ALERT_BOTH = 2'h2;  // Wake and also flag

  // Consecutive samples above threshold that make a detection
  localparam logic [3:0] DETECT_HOLD = 4'h8;
  // Envelope smoothing shift
  localparam int ENV_SHIFT = 4;

  // Four record channels of one microphone path
  typedef struct packed {
    logic              valid;  // One-cycle strobe of a new frame
    logic [3:0][15:0]  data;   // Signed samples, channel 3 high
  } sample_bus_t;

  typedef enum logic [2:0] {
    ST_MONITOR   = 3'b001,
    ST_ALERTED   = 3'b010,
    ST_RECORDING = 3'b100
  } detect_state_t;

  // Magnitude of a signed 17-bit value, saturated to 16 bits
  function automatic logic [15:0] mag16(input logic signed [16:0] x);
    logic [16:0] a;
    a = x[16] ? 17'(-x) : 17'(x);
    mag16 = a[16] ? 16'hffff : a[15:0];
  endfunction

  // One step of a first-order envelope follower
  function automatic logic [15:0] env_step(input logic [15:0] env, input logic [15:0] mag);
    logic signed [17:0] diff;
    diff = $signed({2'b00, mag}) - $signed({2'b00, env});
    env_step = 16'($signed({2'b00, env}) + (diff >>> ENV_SHIFT));
  endfunction

endpackage

// ==== src/activity_core.sv ====
`timescale 1ns/1ps
// Envelope detectors for voice band and ultrasonic band on one sample stream
module activity_core (
  input  wire logic        pclk,         // System clock
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        ce,           // Clock enable
  input  wire logic        armed,        // Detection running
  input  wire logic        voice_on,     // Voice path enabled
  input  wire logic        ultra_on,     // Ultrasonic path enabled
  input  wire logic [15:0] threshold,    // Envelope level for a hit
  input  wire logic        sample_valid, // New sample strobe
  input  wire logic [15:0] sample,       // Signed sample
  output logic             voice_hit,    // One-cycle detection pulse
  output logic             ultra_hit     // One-cycle detection pulse
);

  logic [15:0] prev;       // Previous sample for the high-pass difference
  logic [15:0] voice_env;  // Broadband envelope
  logic [15:0] ultra_env;  // High-pass envelope
  logic [3:0]  voice_run;  // Consecutive samples above threshold
  logic [3:0]  ultra_run;

  // First difference acts as a crude high-pass, leaving mostly high band energy
  wire logic signed [16:0] hp_diff  = $signed({sample[15], sample}) - $signed({prev[15], prev});
  wire logic [15:0] voice_mag       = detect_pkg::mag16({sample[15], sample});
  wire logic [15:0] ultra_mag       = detect_pkg::mag16(hp_diff);
  wire logic [15:0] next_voice_env  = detect_pkg::env_step(voice_env, voice_mag);
  wire logic [15:0] next_ultra_env  = detect_pkg::env_step(ultra_env, ultra_mag);
  wire logic        voice_above     = next_voice_env > threshold;
  wire logic        ultra_above     = next_ultra_env > threshold;
  wire logic        step            = armed && sample_valid;

  // Envelopes restart from zero when disarmed so a re-arm never fires on stale energy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev      <= 16'h0000;
      voice_env <= 16'h0000;
      ultra_env <= 16'h0000;
    end
    else if (ce && !armed)
    begin
      voice_env <= 16'h0000;
      ultra_env <= 16'h0000;
      // Keep the difference history current so the first armed step is a true difference
      if (sample_valid)
        prev <= sample;
    end
    else if (ce && step)
    begin
      prev      <= sample;
      voice_env <= next_voice_env;
      ultra_env <= next_ultra_env;
    end
  end

  // Hit after DETECT_HOLD consecutive samples above threshold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      voice_run <= 4'h0;
      ultra_run <= 4'h0;
      voice_hit <= 1'b0;
      ultra_hit <= 1'b0;
    end
    else if (ce)
    begin
      voice_hit <= 1'b0;
      ultra_hit <= 1'b0;
      if (!armed)
      begin
        voice_run <= 4'h0;
        ultra_run <= 4'h0;
      end
      else if (sample_valid)
      begin
        voice_run <= (voice_on && voice_above) ? voice_run + 4'h1 : 4'h0;
        ultra_run <= (ultra_on && ultra_above) ? ultra_run + 4'h1 : 4'h0;
        voice_hit <= voice_on && voice_above && voice_run == detect_pkg::DETECT_HOLD - 4'h1;
        ultra_hit <= ultra_on && ultra_above && ultra_run == detect_pkg::DETECT_HOLD - 4'h1;
      end
    end
  end

endmodule

// ==== src/low_power_activity_detection.sv ====
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Low-power activity detection: voice and ultrasonic watch on one record channel
module low_power_activity_detection (
  input  wire logic                     pclk,          // 25 MHz clock
  input  wire logic                     presetn,       // Async reset, active low
  input  wire logic                     ce,            // Clock enable, freezes all state
  input  wire logic                     psel,          // APB select
  input  wire logic                     penable,       // APB enable
  input  wire logic                     pwrite,        // APB direction
  input  wire logic [11:0]              paddr,         // APB byte address
  input  wire logic [31:0]              pwdata,        // APB write data
  output logic [31:0]                   prdata,        // APB read data
  output logic                          pready,        // APB ready
  output logic                          pslverr,       // APB error on unmapped address
  input  wire detect_pkg::sample_bus_t  ana_in,        // Analog microphone path
  input  wire detect_pkg::sample_bus_t  dig_in,        // Digital microphone path
  output logic                          irq,           // Level interrupt
  output logic                          record_start,  // One-cycle wake pulse
  output logic                          record_active, // Recording after auto wake
  output logic                          monitoring     // Detector armed and enabled
);

  // Software-visible state
  logic                       voice_detect_enable;      // Voice watch enable
  logic                       ultrasonic_detect_enable; // Ultrasonic watch enable
  logic [1:0]                 detect_alert_select;      // Alert mode
  logic [1:0]                 detect_input_select;      // Monitored channel
  logic                       source_digital;           // Digital path when set
  logic [15:0]                threshold;                // Envelope hit level
  logic [1:0]                 status;                   // Sticky events
  logic [1:0]                 mask;                     // Interrupt mask
  detect_pkg::detect_state_t  state;                    // Alert sequencer
  detect_pkg::detect_state_t  next_state;
  logic                       voice_hit;                // From detector
  logic                       ultra_hit;

  // APB decode: the setup cycle loads read data, the access cycle completes
  wire logic setup_phase  = psel && !penable;
  wire logic wr_access    = psel && penable && pwrite && pready;
  wire logic sel_en       = paddr == detect_pkg::DETECT_EN_ADDR;
  wire logic sel_alert    = paddr == detect_pkg::ALERT_CFG_ADDR;
  wire logic sel_src      = paddr == detect_pkg::SOURCE_CFG_ADDR;
  wire logic sel_status   = paddr == detect_pkg::STATUS_ADDR;
  wire logic sel_mask     = paddr == detect_pkg::MASK_ADDR;
  wire logic sel_record   = paddr == detect_pkg::RECORD_ADDR;
  wire logic mapped       = sel_en || sel_alert || sel_src || sel_status || sel_mask || sel_record;

  // Read multiplexer; unused bits read as zero
  wire logic [31:0] rd_en     = 32'({ultrasonic_detect_enable, voice_detect_enable, 2'b00});
  wire logic [31:0] rd_alert  = 32'({detect_alert_select, detect_input_select, 4'h0});
  wire logic [31:0] rd_src    = 32'({source_digital, threshold});
  wire logic [31:0] next_prdata =
      sel_en     ? rd_en :
      sel_alert  ? rd_alert :
      sel_src    ? rd_src :
      sel_status ? 32'(status) :
      sel_mask   ? 32'(mask) :
      sel_record ? 32'(record_active) : 32'h0000_0000;

  // Source and channel selection feeding the detector
  wire detect_pkg::sample_bus_t src = source_digital ? dig_in : ana_in;
  wire logic [15:0] chan_sample     = src.data[detect_input_select];
  wire logic        armed           = state == detect_pkg::ST_MONITOR;
  wire logic        any_enable      = voice_detect_enable || ultrasonic_detect_enable;

  // Event bookkeeping; a new event wins over a clear in the same cycle
  wire logic [1:0] events      = {ultra_hit, voice_hit};
  wire logic [1:0] status_w1c  = (wr_access && sel_status) ? pwdata[1:0] : 2'h0;
  // Pure wake mode records without flagging, so no interrupt follows an auto wake
  wire logic       wake_only   = detect_alert_select == detect_pkg::ALERT_WAKE;
  wire logic [1:0] flag_events = wake_only ? 2'h0 : events;
  wire logic [1:0] next_status = (status & ~status_w1c) | flag_events;
  wire logic       stop_write  = wr_access && sel_record && pwdata[detect_pkg::RECORD_BIT];
  wire logic       detected    = |events;
  wire logic       wake_mode   = detect_alert_select == detect_pkg::ALERT_WAKE ||
                                 detect_alert_select == detect_pkg::ALERT_BOTH;

  activity_core u_core (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .armed        (armed),
    .voice_on     (voice_detect_enable),
    .ultra_on     (ultrasonic_detect_enable),
    .threshold    (threshold),
    .sample_valid (src.valid),
    .sample       (chan_sample),
    .voice_hit    (voice_hit),
    .ultra_hit    (ultra_hit)
  );

  // Alert sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      detect_pkg::ST_MONITOR:
      begin
        if (detected)
          next_state = wake_mode ? detect_pkg::ST_RECORDING
                                 : detect_pkg::ST_ALERTED;
      end
      detect_pkg::ST_ALERTED:
      begin
        // Re-arm only once software has acknowledged every flag
        if (next_status == 2'h0)
          next_state = detect_pkg::ST_MONITOR;
      end
      detect_pkg::ST_RECORDING:
      begin
        // Recording runs until software stops it; monitoring is paused meanwhile
        if (stop_write)
          next_state = detect_pkg::ST_MONITOR;
      end
      default:
        next_state = detect_pkg::ST_MONITOR;
    endcase
  end

  // APB answer registers: zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !mapped;
      if (setup_phase)
        prdata <= next_prdata;
    end
  end

  // Control registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      voice_detect_enable      <= 1'b0;
      ultrasonic_detect_enable <= 1'b0;
      detect_alert_select      <= detect_pkg::ALERT_IRQ;
      detect_input_select      <= 2'h0;
      source_digital           <= 1'b0;
      threshold                <= detect_pkg::THRESHOLD_RESET;
      mask                     <= detect_pkg::MASK_RESET;
    end
    else if (ce && wr_access)
    begin
      if (sel_en)
      begin
        voice_detect_enable      <= pwdata[detect_pkg::VOICE_EN_BIT];
        ultrasonic_detect_enable <= pwdata[detect_pkg::ULTRA_EN_BIT];
      end
      if (sel_alert)
      begin
        detect_alert_select <= pwdata[detect_pkg::ALERT_LSB +: 2];
        detect_input_select <= pwdata[detect_pkg::CHAN_LSB +: 2];
      end
      if (sel_src)
      begin
        source_digital <= pwdata[detect_pkg::SRC_DIGITAL_BIT];
        threshold      <= pwdata[15:0];
      end
      if (sel_mask)
        mask <= pwdata[1:0];
    end
  end

  // Status, sequencer state and block outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status        <= 2'h0;
      state         <= detect_pkg::ST_MONITOR;
      irq           <= 1'b0;
      record_start  <= 1'b0;
      record_active <= 1'b0;
      monitoring    <= 1'b0;
    end
    else if (ce)
    begin
      status        <= next_status;
      state         <= next_state;
      irq           <= |(next_status & mask);
      record_start  <= state == detect_pkg::ST_MONITOR &&
                       next_state == detect_pkg::ST_RECORDING;
      record_active <= next_state == detect_pkg::ST_RECORDING;
      monitoring    <= next_state == detect_pkg::ST_MONITOR && any_enable;
    end
  end

endmodule

// ==== tb/detect_props.sv ====
`timescale 1ns/1ps
// Pin-level checks of bus timing and alert behaviour
module detect_props (
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Async reset, active low
  input wire logic        ce,            // Clock enable
  input wire logic        psel,          // APB select
  input wire logic        penable,       // APB enable
  input wire logic        pwrite,        // APB direction
  input wire logic [11:0] paddr,         // APB address
  input wire logic [31:0] pwdata,        // APB write data
  input wire logic        pready,        // APB ready
  input wire logic        pslverr,       // APB error
  input wire logic        irq,           // Interrupt
  input wire logic        record_start,  // Wake pulse
  input wire logic        record_active, // Recording
  input wire logic        monitoring     // Armed
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only a completed write may end a held state
  wire logic wr_done = psel && penable && pwrite && pready;
  wire logic en_wr   = wr_done && paddr == detect_pkg::DETECT_EN_ADDR;
  chk_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("pready missing after setup");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_irq_held_ack: assert property (irq && !wr_done && !$past(wr_done) |=> irq)
    else $error("irq dropped without a write");
  chk_start_one_cycle: assert property (record_start |=> !record_start)
    else $error("record_start longer than one cycle");
  chk_start_records: assert property (record_start |-> ##[0:1] record_active)
    else $error("record_start without recording");
  chk_record_held: assert property (record_active && !wr_done |=> record_active)
    else $error("recording stopped without a write");
  chk_enable_arms: assert property (en_wr && pwdata[2] && !irq && !record_active
    |=> ##1 monitoring)
    else $error("voice enable did not arm");
  chk_disable_idles: assert property (en_wr && pwdata[3:2] == 2'h0 |=> ##1 !monitoring)
    else $error("monitoring with both enables off");
  cover property (record_start);
  cover property ($rose(irq));
  cover property (pslverr);
endmodule

bind low_power_activity_detection detect_props u_detect_props (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .record_start(record_start), .record_active(record_active), .monitoring(monitoring));

// ==== tb/mic_model.sv ====
`timescale 1ns/1ps
// Both microphone paths; a loud tone on one channel of one path, zeros elsewhere
module mic_model (
  input  wire logic          pclk,    // Clock
  input  wire logic          presetn, // Async reset, active low
  input  wire logic          use_dig, // Tone on digital path
  input  wire logic [1:0]    ch,      // Channel carrying the tone
  input  wire logic          alt,     // Alternate sign, ultrasonic content
  input  wire logic          on,      // Tone present
  output detect_pkg::sample_bus_t ana, // Analog path frames
  output detect_pkg::sample_bus_t dig  // Digital path frames
);
  logic ph; // Sign phase
  // Zeros on the idle path, so a wrong source choice never sees the tone
  wire logic [15:0] tone = (alt && ph) ? 16'h8001 : 16'h7fff;
  // A frame every cycle, the densest rate allowed
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ana <= '0;
      dig <= '0;
      ph  <= 1'b0;
    end
    else
    begin
      ph <= !ph;
      ana <= '{valid: 1'b1, data: '0};
      dig <= '{valid: 1'b1, data: '0};
      if (on && use_dig) dig.data[ch] <= tone;
      if (on && !use_dig) ana.data[ch] <= tone;
    end
endmodule

// ==== tb/low_power_activity_detection_tb.sv ====
`timescale 1ns/1ps
// Register-level tests of the activity detector
module low_power_activity_detection_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, err, irq, record_start, record_active, monitoring;
  logic        use_dig, alt, mic_on, wake;
  logic [1:0]  mic_ch;
  detect_pkg::sample_bus_t ana_in, dig_in;
  int          fails, cmp_count, m, starts;
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  low_power_activity_detection u_low_power_activity_detection (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ana_in(ana_in), .dig_in(dig_in), .irq(irq),
    .record_start(record_start), .record_active(record_active),
    .monitoring(monitoring));
  mic_model u_mic_model (.pclk(pclk), .presetn(presetn), .use_dig(use_dig),
    .ch(mic_ch), .alt(alt), .on(mic_on), .ana(ana_in), .dig(dig_in));
  // Count wake pulses so each auto wake is seen exactly once
  always @(posedge pclk) if (record_start === 1'b1) starts <= starts + 1;
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One transfer; request held until pready is seen at an edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      $display("unexpected pready exp 1 got 0");
      end_of_test;
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(nm, rdat, exp);
  endtask
  // Bounded wait for the alert of the chosen mode
  task wait_for(input logic w);
    int n;
    for (n = 0; n < 200 && (w ? record_active : irq) !== 1'b1; n++)
      @(posedge pclk);
    if ((w ? record_active : irq) !== 1'b1)
    begin
      fails++;
      $display("unexpected %s exp 1 got 0", w ? "record_active" : "irq");
      end_of_test;
    end
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, use_dig, alt, mic_on, mic_ch} = '0;
    {paddr, pwdata, fails, cmp_count} = '0;
    ce = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("mask", detect_pkg::MASK_ADDR, 32'h3);
    rd("source", detect_pkg::SOURCE_CFG_ADDR, 32'h800);
    rd("enable", detect_pkg::DETECT_EN_ADDR, 32'h0);
    rd("hole", 12'h3f0, 32'h0);
    check("pslverr", {31'h0, err}, 32'h1);
    $display("test reset done");
    // Every alert mode, each on its own channel, paths alternating
    for (m = 0; m < 4; m++)
    begin
      use_dig <= m[0];
      mic_ch <= m[1:0];
      mic_on <= 1'b1;
      wake = (m == 1 || m == 2);
      wr(detect_pkg::SOURCE_CFG_ADDR, {15'h0, m[0], 16'h0100});
      wr(detect_pkg::ALERT_CFG_ADDR, {24'h0, m[1:0], m[1:0], 4'h0});
      wr(detect_pkg::DETECT_EN_ADDR, 32'h4);
      wait_for(wake);
      rd("status", detect_pkg::STATUS_ADDR, {31'h0, m != 1});
      rd("record", detect_pkg::RECORD_ADDR, {31'h0, wake});
      if (m == 0)
      begin
        check("monitoring", {31'h0, monitoring}, 32'h0);
        wr(detect_pkg::STATUS_ADDR, 32'h1);
        @(posedge pclk);
        check("irq", {31'h0, irq}, 32'h0);
        wait_for(1'b0);
      end
      mic_on <= 1'b0;
      if (wake) wr(detect_pkg::RECORD_ADDR, 32'h1);
      wr(detect_pkg::STATUS_ADDR, 32'h3);
      wr(detect_pkg::DETECT_EN_ADDR, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      rd("record", detect_pkg::RECORD_ADDR, 32'h0);
      $display("test mode %0d done", m);
    end
    check("record_start", starts, 32'h2);
    // Ultrasonic tone with the interrupt masked, then unmasked
    wr(detect_pkg::MASK_ADDR, 32'h0);
    {use_dig, mic_ch, alt, mic_on} <= 5'b00111;
    wr(detect_pkg::SOURCE_CFG_ADDR, 32'h100);
    wr(detect_pkg::ALERT_CFG_ADDR, 32'h10);
    wr(detect_pkg::DETECT_EN_ADDR, 32'h8);
    repeat (40) @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h0);
    rd("status", detect_pkg::STATUS_ADDR, 32'h2);
    wr(detect_pkg::MASK_ADDR, 32'h3);
    rd("mask", detect_pkg::MASK_ADDR, 32'h3);
    check("irq", {31'h0, irq}, 32'h1);
    {alt, mic_on} <= 2'b00;
    wr(detect_pkg::STATUS_ADDR, 32'h2);
    rd("status", detect_pkg::STATUS_ADDR, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    wr(detect_pkg::DETECT_EN_ADDR, 32'h0);
    $display("test ultrasonic done");
    // Tone on digital channel 2: wrong channel, then wrong path
    for (m = 0; m < 2; m++)
    begin
      {use_dig, mic_ch, mic_on} <= 4'b1101;
      wr(detect_pkg::SOURCE_CFG_ADDR, m ? 32'h100 : 32'h10100);
      wr(detect_pkg::ALERT_CFG_ADDR, m ? 32'h20 : 32'h0);
      wr(detect_pkg::DETECT_EN_ADDR, 32'h4);
      repeat (40) @(posedge pclk);
      rd("status", detect_pkg::STATUS_ADDR, 32'h0);
      wr(detect_pkg::DETECT_EN_ADDR, 32'h0);
    end
    $display("test selection done");
    end_of_test;
  end
endmodule
